// ### pcm_pkg.sv
// constants and types for the 16-bit card memory cycle timer
// Operation
// [RL1] read: address, select, enables driven setup cycles before read strobe
// [RL2] read strobe low for programmed width 3..31, stretched by card wait
// [RL3] read: address, select, enables held hold cycles after strobe rises
// [RL4] read strobe stays low at least one cycle after wait release
// [RL5] write: address, select, enables driven setup cycles before strobe
// [RL6] write strobe low for programmed width 3..31, stretched by card wait
// [RL7] write: address, select, enables held hold cycles after strobe rises
// [RL8] write data driven setup cycles before write strobe falls
// [RL9] write data kept driven hold cycles after write strobe rises
// [RL10] write strobe stays low at least one cycle after wait release
// [RL11] setup, width and hold counts come from software timing setting
// [RL12] card asserts wait within 50 ns of strobe fall when stretching
// [RL13] status change reaches selected interrupt output within two cycles
// [RL14] card interrupt request forwarded to selected output without clocking
// [RL15] host holds reset 1 ms and runs clock 100 us first; testbench power-up reset lasts 5 cycles
// [RL16] card ring indicate passed to system ring output unclocked
// [RL17] wait sampled on host clock; strobe ends only after release seen
package pcm_pkg;
   // ==========================================
   // timing
   localparam int CLK_NS = 50;
   localparam int WAIT_DLY_NS = 50;
   localparam int SYNC_STAGES = 2;
   // card wait latency plus synchroniser; strobe never shorter than this
   localparam int WAIT_GUARD_CYC =
      (WAIT_DLY_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   localparam int STATUS_IRQ_CYC = 2;
   // ==========================================
   // field limits
   localparam logic [2:0] SETUP_MIN = 3'h1;
   localparam logic [4:0] WIDTH_MIN = 5'h3;
   localparam logic [2:0] HOLD_MIN = 3'h1;
   localparam logic [4:0] CNT_MAX = 5'h1F;
   localparam logic [4:0] GUARD_CNT = WAIT_GUARD_CYC[4:0];
   localparam logic [1:0] CE_OFF = 2'h3;
   // ==========================================
   // states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_STROBE = 2'b10,
      ST_HOLD = 2'b11
   } pcm_st_t;
endpackage

// ### pcm_sync.sv
// two-flop synchroniser for card pins
`timescale 1ns/1ps
module pcm_sync
   import pcm_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } pcm_sync_t;
   pcm_sync_t s_reg;
   pcm_sync_t s_next;

   always_comb
   begin
      s_next.meta = d;
      s_next.sync = s_reg.meta;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_reg <= {RST_VAL, RST_VAL};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.sync;
endmodule

// ### pcm_cycle.sv
// 16-bit card memory cycle timer with status and ring forwarding
`timescale 1ns/1ps
module pcm_cycle
   import pcm_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [2:0] cfg_setup,
   input wire logic [4:0] cfg_width,
   input wire logic [2:0] cfg_hold,
   input wire logic cfg_irq_gp,
   input wire logic req,
   input wire logic req_write,
   input wire logic [25:0] req_addr,
   input wire logic req_reg,
   input wire logic [1:0] req_ce,
   input wire logic [15:0] req_wdata,
   output logic busy,
   output logic done,
   output logic [15:0] rd_data,
   output logic [25:0] card_addr,
   output logic card_reg_n,
   output logic [1:0] card_ce_n,
   output logic card_oe_n,
   output logic card_we_n,
   output logic [15:0] card_data_o,
   output logic card_data_oe,
   input wire logic [15:0] card_data_i,
   input wire logic card_wait_n,
   input wire logic card_status_chg,
   input wire logic status_clr,
   input wire logic card_irq_req_n,
   input wire logic card_ring_in_n,
   output logic sys_ring_out_n,
   output logic gp_irq_n,
   output logic bus_int_n
);
   // ==========================================
   // state
   typedef struct packed {
      pcm_st_t st;
      logic [4:0] cnt;
      logic wr;
      logic [2:0] setup;
      logic [4:0] wid;
      logic [2:0] hold;
      logic [25:0] addr;
      logic reg_n;
      logic [1:0] ce_n;
      logic oe_n;
      logic we_n;
      logic [15:0] dout;
      logic doe;
      logic [15:0] rdata;
      logic done;
      logic sc;
      logic busy;
   } pcm_state_t;
   pcm_state_t s_reg;
   pcm_state_t s_next;
   logic wait_n_s;
   logic [15:0] data_s;
   logic [4:0] wid_eff;
   logic strobe_end;

   // ==========================================
   // pin synchronisers
   pcm_sync #(.W(1), .RST_VAL(1'b1)) u_wait_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .d(card_wait_n),
      .q(wait_n_s)
   );
   // data is stable while the strobe is low, so a late copy is safe
   pcm_sync #(.W(16), .RST_VAL(16'h0000)) u_data_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .d(card_data_i),
      .q(data_s)
   );

   // ==========================================
   // effective width: never below the wait guard so a stretch is seen
   always_comb
   begin
      wid_eff = cfg_width;
      if (wid_eff < WIDTH_MIN)
      begin
         wid_eff = WIDTH_MIN;
      end
      if (wid_eff < GUARD_CNT)
      begin
         wid_eff = GUARD_CNT;
      end
   end

   // released wait seen, registered strobe adds the extra cycle
   assign strobe_end = (s_reg.cnt >= s_reg.wid)
      && wait_n_s; // [RL17] [RL4] [RL10]

   // ==========================================
   // next state
   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (s_reg.cnt != CNT_MAX)
      begin
         s_next.cnt = s_reg.cnt + 5'h01;
      end
      // set wins over clear
      if (card_status_chg)
      begin
         s_next.sc = 1'b1; // [RL13]
      end
      else if (status_clr)
      begin
         s_next.sc = 1'b0;
      end
      case (s_reg.st)
         ST_IDLE:
         begin
            if (req)
            begin
               s_next.st = ST_SETUP;
               s_next.cnt = 5'h01;
               s_next.wr = req_write;
               s_next.setup = (cfg_setup == 3'h0) ? SETUP_MIN
                  : cfg_setup; // [RL11]
               s_next.hold = (cfg_hold == 3'h0) ? HOLD_MIN
                  : cfg_hold; // [RL11]
               s_next.wid = wid_eff; // [RL11]
               s_next.addr = req_addr; // [RL1] [RL5]
               s_next.reg_n = ~req_reg;
               s_next.ce_n = ~req_ce;
               s_next.dout = req_wdata;
               s_next.doe = req_write; // [RL8]
               s_next.busy = 1'b1;
            end
         end
         ST_SETUP:
         begin
            if (s_reg.cnt >= {2'b00, s_reg.setup}) // [RL1] [RL5] [RL8]
            begin
               s_next.st = ST_STROBE;
               s_next.cnt = 5'h01;
               s_next.oe_n = s_reg.wr;
               s_next.we_n = ~s_reg.wr;
            end
         end
         ST_STROBE:
         begin
            if (strobe_end) // [RL2] [RL6]
            begin
               s_next.st = ST_HOLD;
               s_next.cnt = 5'h01;
               s_next.oe_n = 1'b1;
               s_next.we_n = 1'b1;
               if (!s_reg.wr)
               begin
                  s_next.rdata = data_s;
               end
            end
         end
         ST_HOLD:
         begin
            if (s_reg.cnt >= {2'b00, s_reg.hold}) // [RL3] [RL7] [RL9]
            begin
               s_next.st = ST_IDLE;
               s_next.ce_n = CE_OFF;
               s_next.reg_n = 1'b1;
               s_next.doe = 1'b0;
               s_next.done = 1'b1;
               s_next.busy = 1'b0;
            end
         end
         default:
         begin
            s_next.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_reg <= '{st: ST_IDLE, cnt: 5'h00, wr: 1'b0, setup: SETUP_MIN,
                    wid: WIDTH_MIN, hold: HOLD_MIN, addr: 26'h0000000,
                    reg_n: 1'b1, ce_n: CE_OFF, oe_n: 1'b1, we_n: 1'b1,
                    dout: 16'h0000, doe: 1'b0, rdata: 16'h0000,
                    done: 1'b0, sc: 1'b0, busy: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ==========================================
   // outputs
   assign busy = s_reg.busy;
   assign done = s_reg.done;
   assign rd_data = s_reg.rdata;
   assign card_addr = s_reg.addr;
   assign card_reg_n = s_reg.reg_n;
   assign card_ce_n = s_reg.ce_n;
   assign card_oe_n = s_reg.oe_n;
   assign card_we_n = s_reg.we_n;
   assign card_data_o = s_reg.dout;
   assign card_data_oe = s_reg.doe;
   // asynchronous paths: a clocked stage would break the delay budget
   assign sys_ring_out_n = card_ring_in_n; // [RL16]
   assign gp_irq_n = ~(cfg_irq_gp & (s_reg.sc | ~card_irq_req_n)); // [RL14]
   assign bus_int_n = ~(~cfg_irq_gp & (s_reg.sc | ~card_irq_req_n)); // [RL14]

   // ==========================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   read_setup_a: assert property ( // [RL1]
      $fell(card_oe_n) |-> $past(s_reg.cnt) == {2'b00, $past(s_reg.setup)}
         && $past(card_ce_n) != CE_OFF && $stable(card_addr))
      else $error("read strobe fell before setup count");
   write_setup_a: assert property ( // [RL5]
      $fell(card_we_n) |-> $past(s_reg.cnt) == {2'b00, $past(s_reg.setup)}
         && $past(card_ce_n) != CE_OFF)
      else $error("write strobe fell before setup count");
   wdata_setup_a: assert property ( // [RL8]
      $fell(card_we_n) |-> $past(card_data_oe, 1) && $stable(card_data_o))
      else $error("write data not driven before strobe");
   read_width_a: assert property ( // [RL2]
      $rose(card_oe_n) |-> $past(s_reg.cnt) >= $past(s_reg.wid)
         && $past(s_reg.wid) >= WIDTH_MIN)
      else $error("read strobe too short");
   write_width_a: assert property ( // [RL6]
      $rose(card_we_n) |-> $past(s_reg.cnt) >= $past(s_reg.wid))
      else $error("write strobe too short");
   wait_release_a: assert property ( // [RL4] [RL10] [RL17]
      (!card_oe_n || !card_we_n) && !wait_n_s |=> !card_oe_n || !card_we_n)
      else $error("strobe ended while wait held");
   addr_hold_a: assert property ( // [RL3] [RL7]
      s_reg.st == ST_HOLD |-> $stable(card_addr) && card_ce_n != CE_OFF)
      else $error("address moved during hold");
   wdata_hold_a: assert property ( // [RL9]
      $rose(card_we_n) |-> card_data_oe [*1] ##1
         (card_data_oe || done))
      else $error("write data dropped during hold");
   cycle_end_a: assert property ( // [RL11]
      s_reg.st == ST_HOLD && s_reg.cnt >= {2'b00, s_reg.hold}
         |=> done && card_ce_n == CE_OFF && !card_data_oe)
      else $error("cycle did not close after hold");
   status_irq_a: assert property ( // [RL13]
      card_status_chg |-> ##1 (cfg_irq_gp ? !gp_irq_n : !bus_int_n))
      else $error("status change not signalled");
   ring_path_a: assert property ( // [RL16]
      sys_ring_out_n == card_ring_in_n)
      else $error("ring output differs from card ring");
endmodule

// ### pcm_card_model.sv
// card-side model: memory data and wait stretch
`timescale 1ns/1ps
module pcm_card_model
(
   input wire logic mclk,
   input wire logic [25:0] card_addr,
   input wire logic card_oe_n,
   input wire logic card_we_n,
   input wire logic [15:0] card_data_o,
   output logic [15:0] card_data_i,
   output logic card_wait_n,
   input wire logic [3:0] wait_cyc,
   output logic [15:0] wr_seen
);
   logic [15:0] last;
   wire strobe_n = card_oe_n & card_we_n;
   initial
   begin
      card_wait_n = 1'h1;
      last = 16'h0000;
      wr_seen = 16'h0000;
   end
   // released bus shows inverted last value, never a stale match
   assign card_data_i = card_oe_n ? ~last : card_addr[15:0] ^ 16'h5A5A;
   always @(posedge mclk)
      if (!card_oe_n)
         last <= card_data_i;
   always @(posedge card_we_n)
      wr_seen = card_data_o;
   always @(negedge strobe_n)
   begin
      if (wait_cyc > 0)
      begin
         #10 card_wait_n = 1'h0;
         repeat (wait_cyc) @(posedge mclk);
         #5 card_wait_n = 1'h1;
      end
   end
endmodule

// ### tb_pccard16_memory_cycle_timing.sv
// testbench for the 16-bit card memory cycle timer
`timescale 1ns/1ps
module tb_pccard16_memory_cycle_timing;
   logic mclk, sys_rst, cfg_irq_gp, req, req_write, req_reg, busy, done;
   logic [2:0] cfg_setup, cfg_hold;
   logic [4:0] cfg_width;
   logic [25:0] req_addr, card_addr;
   logic [1:0] req_ce, card_ce_n;
   logic [15:0] req_wdata, rd_data, card_data_o, card_data_i, wr_seen;
   logic card_reg_n, card_oe_n, card_we_n, card_data_oe, card_wait_n;
   logic card_status_chg, status_clr, card_irq_req_n, card_ring_in_n;
   logic sys_ring_out_n, gp_irq_n, bus_int_n;
   logic [3:0] wait_cyc;
   int err_total, checks;
   pcm_cycle DUT (.mclk(mclk), .sys_rst(sys_rst), .cfg_setup(cfg_setup),
      .cfg_width(cfg_width), .cfg_hold(cfg_hold), .cfg_irq_gp(cfg_irq_gp),
      .req(req), .req_write(req_write), .req_addr(req_addr),
      .req_reg(req_reg), .req_ce(req_ce), .req_wdata(req_wdata),
      .busy(busy), .done(done), .rd_data(rd_data), .card_addr(card_addr),
      .card_reg_n(card_reg_n), .card_ce_n(card_ce_n),
      .card_oe_n(card_oe_n), .card_we_n(card_we_n),
      .card_data_o(card_data_o), .card_data_oe(card_data_oe),
      .card_data_i(card_data_i), .card_wait_n(card_wait_n),
      .card_status_chg(card_status_chg), .status_clr(status_clr),
      .card_irq_req_n(card_irq_req_n), .card_ring_in_n(card_ring_in_n),
      .sys_ring_out_n(sys_ring_out_n), .gp_irq_n(gp_irq_n),
      .bus_int_n(bus_int_n));
   pcm_card_model card (.mclk(mclk), .card_addr(card_addr),
      .card_oe_n(card_oe_n), .card_we_n(card_we_n),
      .card_data_o(card_data_o), .card_data_i(card_data_i),
      .card_wait_n(card_wait_n), .wait_cyc(wait_cyc), .wr_seen(wr_seen));
   // ==========================================
   // reporting
   task automatic ck(input logic ok, input string m);
      checks++;
      if (ok !== 1'h1)
      begin
         err_total++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   function automatic logic idle_ok();
      return busy === 1'h0 && done === 1'h0 && rd_data === 16'h0000 &&
         card_addr === 26'h0000000 && card_reg_n === 1'h1 &&
         card_ce_n === 2'h3 && card_oe_n === 1'h1 && card_we_n === 1'h1 &&
         card_data_oe === 1'h0;
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // one memory cycle, timed on the card pins
   task automatic cyc(input logic wr, input logic [2:0] s,
      input logic [4:0] w, input logic [2:0] h, input logic [3:0] wc,
      input logic [25:0] a, input logic [15:0] d);
      int su, pw, hl, rel, n;
      logic low, st, ok;
      su = 0;
      pw = 0;
      hl = 0;
      rel = 0;
      low = 1'h0;
      ok = 1'h1;
      @(posedge mclk);
      cfg_setup <= s;
      cfg_width <= w;
      cfg_hold <= h;
      req <= 1'h1;
      req_write <= wr;
      req_addr <= a;
      req_reg <= a[0];
      req_ce <= {a[1], 1'h1};
      req_wdata <= d;
      wait_cyc <= wc;
      @(posedge mclk);
      req <= 1'h0;
      for (n = 0; n < 400; n++)
      begin
         #1;
         if (done === 1'h1)
            break;
         st = wr ? card_we_n : card_oe_n;
         if (busy !== 1'h1 || card_ce_n !== ~{a[1], 1'h1} || card_addr !== a ||
            card_reg_n !== ~a[0] || card_data_oe !== wr ||
            (wr && card_data_o !== d) || (wr ? card_oe_n : card_we_n) !== 1'h1)
            ok = 1'h0;
         if (st === 1'h0)
         begin
            pw++;
            if (card_wait_n === 1'h1 && low && rel == 0)
               rel = pw;
         end
         else if (pw == 0)
            su++;
         else
            hl++;
         if (card_wait_n === 1'h0)
            low = 1'h1;
         @(posedge mclk);
         // a second request while busy must be ignored
         req <= (pw == 1);
         req_addr <= (pw == 1) ? ~a : a;
      end
      if (n == 400)
      begin
         err_total++;
         $display("MISMATCH %0t no done", $time);
         stop_test();
      end
      ck(ok, "pins moved in cycle");
      ck(su == ((s == 0) ? 1 : s), "setup");
      ck(hl == ((h == 0) ? 1 : h), "hold");
      ck((wc == 0) ? pw == ((w < 3) ? 3 : w)
         : (pw >= w && rel > 0 && pw > rel),
         "width");
      ck(card_ce_n === 2'h3 && card_data_oe === 1'h0, "no release");
      ck(wr ? wr_seen === d : rd_data === (a[15:0] ^ 16'h5A5A), "data");
   endtask
   // ==========================================
   // status interrupt, card interrupt and ring paths
   task automatic irq_test();
      int k;
      for (k = 0; k < 2; k++)
      begin
         @(posedge mclk);
         cfg_irq_gp <= k[0];
         card_status_chg <= 1'h1;
         @(posedge mclk);
         card_status_chg <= 1'h0;
         @(posedge mclk);
         #1;
         ck((k[0] ? gp_irq_n : bus_int_n) === 1'h0 &&
            (k[0] ? bus_int_n : gp_irq_n) === 1'h1, "status irq");
         @(posedge mclk);
         status_clr <= 1'h1;
         @(posedge mclk);
         status_clr <= 1'h0;
         card_irq_req_n <= 1'h0;
         card_ring_in_n <= 1'h0;
         #1;
         ck((k[0] ? gp_irq_n : bus_int_n) === 1'h0 &&
            sys_ring_out_n === 1'h0, "card irq or ring");
         @(posedge mclk);
         card_irq_req_n <= 1'h1;
         card_ring_in_n <= 1'h1;
         #1;
         ck(gp_irq_n === 1'h1 && bus_int_n === 1'h1 &&
            sys_ring_out_n === 1'h1, "irq clear");
      end
      // event and clear in one cycle: the event must win
      @(posedge mclk);
      card_status_chg <= 1'h1;
      status_clr <= 1'h1;
      @(posedge mclk);
      card_status_chg <= 1'h0;
      status_clr <= 1'h0;
      #1;
      ck(gp_irq_n === 1'h0, "status set lost to clear");
      @(posedge mclk);
      status_clr <= 1'h1;
      @(posedge mclk);
      status_clr <= 1'h0;
   endtask
   // ==========================================
   // reset in mid-cycle, held 1 ms with the clock running
   task automatic reset_test();
      @(posedge mclk);
      cfg_setup <= 3'h1;
      cfg_width <= 5'h1F;
      wait_cyc <= 4'h0;
      req_write <= 1'h1;
      req <= 1'h1;
      @(posedge mclk);
      req <= 1'h0;
      repeat (4) @(posedge mclk);
      #1;
      ck(card_we_n === 1'h0 && busy === 1'h1, "write strobe");
      @(posedge mclk);
      sys_rst <= 1'h1;
      // 20000 cycles of 50 ns give the 1 ms reset pulse
      repeat (20000) @(posedge mclk);
      sys_rst <= 1'h0;
      @(posedge mclk);
      #1;
      ck(idle_ok(), "mid-run reset");
   endtask
   initial
   begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end
   initial
   begin
      {sys_rst, cfg_irq_gp, req, req_write, req_reg} = 5'h10;
      {cfg_setup, cfg_width, cfg_hold, req_ce, wait_cyc} = 17'h00000;
      {req_addr, req_wdata} = 42'h000_0000_0000;
      {card_status_chg, status_clr, card_irq_req_n, card_ring_in_n} = 4'h3;
      err_total = 0;
      checks = 0;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'h0;
      @(posedge mclk);
      #1;
      ck(idle_ok(), "reset");
      cyc(1'h0, 3'h1, 5'h03, 3'h1, 4'h0, 26'h0000123, 16'h0000);
      cyc(1'h0, 3'h7, 5'h1F, 3'h7, 4'h0, 26'h3FFFFFF, 16'h0000);
      cyc(1'h0, 3'h0, 5'h00, 3'h0, 4'h0, 26'h1555556, 16'h0000);
      cyc(1'h0, 3'h2, 5'h04, 3'h1, 4'h6, 26'h2345679, 16'h0000);
      cyc(1'h1, 3'h2, 5'h03, 3'h2, 4'h0, 26'h2AAAAAA, 16'hC3A5);
      cyc(1'h1, 3'h7, 5'h1F, 3'h7, 4'h0, 26'h0F0F0F1, 16'h5A3C);
      cyc(1'h1, 3'h1, 5'h03, 3'h1, 4'h8, 26'h1234567, 16'hFFFF);
      reset_test();
      cyc(1'h0, 3'h3, 5'h05, 3'h2, 4'h2, 26'h0000ACE, 16'h0000);
      irq_test();
      stop_test();
   end
endmodule
